// >>> design/memory_barrier_ordering_unit.sv
// Barrier sequencing and acquire/release ordering between core and memory system.
//
// Overview of operation
// - Context barrier forces refetch of later instructions.
// - Context barrier waits for context-changing operations.
// - Data order barrier orders earlier data accesses.
// - Data order barrier waits data cache maintenance.
// - Sync barrier stalls every later instruction.
// - Sync barrier waits all maintenance operations.
// - Qualifier gives four domains, three classes.
// - Load class: loads drain, later accesses wait.
// - Store class orders stores only.
// - Full class: all accesses drain and wait.
// - Fetch, data and walker are separate observers.
// - Observed means acknowledged by the memory system.
// - Speculative loads are counted like explicit ones.
// - Later matching accesses wait for acquiring load.
// - Releasing store waits for earlier accesses.
// - Acquire/release domain comes from address attributes.
// - Releasing store visible everywhere after all earlier.
// - Exclusive forms share acquire/release ordering.
`timescale 1ns/100ps
module memory_barrier_ordering_unit
  import barrier_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bar_valid,
  input wire logic [1:0] bar_kind,
  input wire logic [QUAL_W-1:0] bar_qual,
  output logic bar_ready,
  output logic bar_done,
  output logic refetch_req,
  output logic [1:0] bar_domain,
  output logic exec_stall,
  input wire logic ld_valid,
  input wire logic ld_acquire,
  input wire logic ld_excl,
  input wire logic [1:0] ld_domain,
  output logic ld_ready,
  input wire logic spec_valid,
  output logic spec_ready,
  input wire logic ld_ack,
  input wire logic st_valid,
  input wire logic st_release,
  input wire logic st_excl,
  input wire logic [1:0] st_domain,
  output logic st_ready,
  input wire logic st_ack,
  input wire logic dmnt_valid,
  input wire logic dmnt_ack,
  input wire logic smnt_valid,
  input wire logic smnt_ack,
  input wire logic ctx_valid,
  input wire logic ctx_ack,
  input wire logic walk_valid,
  input wire logic walk_ack,
  output logic op_ready,
  input wire logic send_event_req,
  output logic send_event_signal
);

  typedef struct packed {
    bar_state_type st;
    logic [1:0] kind;
    logic [1:0] cls;
    logic [1:0] dom;
    logic done;
    logic refetch;
    logic acq_hold;
    logic [1:0] acq_dom;
  } ctl_state_type;

  ctl_state_type state_ff;
  ctl_state_type nxt_state;

  logic [NUM_CNT-1:0] cnt_inc;
  logic [NUM_CNT-1:0] cnt_dec;
  logic [NUM_CNT-1:0] cnt_zero;
  logic [NUM_CNT-1:0] cnt_full;
  logic drained;
  logic draining;
  logic hold_ld;
  logic hold_st;
  logic hold_all;
  logic ld_acq_like;
  logic st_rel_like;
  logic ld_fire;
  logic st_fire;
  logic spec_fire;
  logic data_bar;

  // Acquire hold applies to accesses in the same domain or a system-wide one.
  function automatic logic dom_match(input logic [1:0] a, input logic [1:0] b);
    dom_match = (a == b) || (a == SYSTEM_DOMAIN_ALL) || (b == SYSTEM_DOMAIN_ALL);
  endfunction : dom_match

  // Unknown class codes fall back to the strongest ordering, never the weakest.
  function automatic logic [1:0] qual_cls(input logic [QUAL_W-1:0] q);
    logic [1:0] c;
    c = q[QUAL_CLS_LSB +: 2];
    qual_cls = (c == CLS_LD || c == CLS_ST) ? c : CLS_ANY;
  endfunction : qual_cls

  // One counter per tracked class; acknowledges mark observation.
  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    outstanding_counter #(
      .CNT_W(CNT_W)
    ) u_cnt (
      .clk(clk),
      .nrst(nrst),
      .inc(cnt_inc[i]),
      .dec(cnt_dec[i]),
      .zero(cnt_zero[i]),
      .full(cnt_full[i])
    );
  end

  drain_check u_drain (
    .kind(state_ff.kind),
    .cls(state_ff.cls),
    .zero(cnt_zero),
    .drained(drained)
  );

  // Exclusive variants carry exactly the same one-way ordering.
  assign ld_acq_like = ld_acquire | ld_excl & ld_acquire;
  assign st_rel_like = st_release | st_excl & st_release;

  // Which later traffic a draining barrier holds back.
  always_comb begin
    draining = (state_ff.st == ST_DRAIN);
    // Only the two data barriers carry a meaningful access class.
    data_bar = draining && (state_ff.kind == KIND_DMB || state_ff.kind == KIND_DSB);
    hold_all = draining && (state_ff.kind == KIND_DSB
                            || state_ff.kind == KIND_CTX);
    hold_ld = draining && state_ff.kind != KIND_CTX
              && state_ff.cls != CLS_ST;
    hold_st = draining && state_ff.kind != KIND_CTX;
  end

  // Handshakes stay combinational so the issue stage sees the stall at once.
  always_comb begin
    bar_ready = (state_ff.st == ST_IDLE);
    ld_ready = !hold_ld && !hold_all && !cnt_full[CNT_LD]
               && !(state_ff.acq_hold && dom_match(state_ff.acq_dom, ld_domain));
    spec_ready = !hold_ld && !hold_all && !cnt_full[CNT_LD] && !ld_valid
                 && !state_ff.acq_hold;
    st_ready = !hold_st && !hold_all && !cnt_full[CNT_ST]
               && !(state_ff.acq_hold && dom_match(state_ff.acq_dom, st_domain))
               && !(st_rel_like && !(cnt_zero[CNT_LD] && cnt_zero[CNT_ST]));
    op_ready = !hold_all && !cnt_full[CNT_DMNT] && !cnt_full[CNT_SMNT]
               && !cnt_full[CNT_CTX] && !cnt_full[CNT_WALK];
    exec_stall = hold_all;
    send_event_signal = send_event_req && !hold_all;
  end

  // Issue and acknowledge strobes feeding the counters.
  always_comb begin
    ld_fire = ld_valid && ld_ready;
    st_fire = st_valid && st_ready;
    spec_fire = spec_valid && spec_ready;
    cnt_inc = '0;
    cnt_inc[CNT_LD] = ld_fire || spec_fire;
    cnt_inc[CNT_ST] = st_fire;
    cnt_inc[CNT_DMNT] = dmnt_valid && op_ready;
    cnt_inc[CNT_SMNT] = smnt_valid && op_ready;
    cnt_inc[CNT_CTX] = ctx_valid && op_ready;
    cnt_inc[CNT_WALK] = walk_valid && op_ready;
    cnt_dec = '0;
    cnt_dec[CNT_LD] = ld_ack;
    cnt_dec[CNT_ST] = st_ack;
    cnt_dec[CNT_DMNT] = dmnt_ack;
    cnt_dec[CNT_SMNT] = smnt_ack;
    cnt_dec[CNT_CTX] = ctx_ack;
    cnt_dec[CNT_WALK] = walk_ack;
  end

  // Barrier sequencer and acquire tracking.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    nxt_state.refetch = 1'b0;
    unique case (state_ff.st)
      ST_IDLE: begin
        if (bar_valid) begin
          nxt_state.st = ST_DRAIN;
          nxt_state.kind = bar_kind;
          nxt_state.cls = qual_cls(bar_qual);
          nxt_state.dom = bar_qual[QUAL_DOM_LSB +: 2];
        end
      end
      ST_DRAIN: begin
        if (drained) begin
          nxt_state.st = ST_IDLE;
          nxt_state.done = 1'b1;
          nxt_state.refetch = (state_ff.kind == KIND_CTX);
        end
      end
    endcase
    // The hold releases once every outstanding load has been observed.
    if (ld_fire && ld_acq_like) begin
      nxt_state.acq_hold = 1'b1;
      nxt_state.acq_dom = ld_domain;
    end else if (state_ff.acq_hold && cnt_zero[CNT_LD]) begin
      nxt_state.acq_hold = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '{st: ST_IDLE, kind: KIND_DMB, cls: CLS_ANY, dom: SYSTEM_DOMAIN_ALL,
                    default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Done and refetch are registered pulses; the domain goes to the interconnect.
  assign bar_done = state_ff.done;
  assign refetch_req = state_ff.refetch;
  assign bar_domain = state_ff.dom;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_bar_take;
    bar_valid && bar_ready;
  endsequence

  sequence s_drain_end;
    draining && drained;
  endsequence

  sequence s_acq_issue;
    ld_valid && ld_ready && ld_acquire;
  endsequence

  // A context barrier that drains must end with a refetch request.
  sequence s_ctx_end;
    draining && drained && state_ff.kind == KIND_CTX;
  endsequence

  AST_DONE_PULSE: assert property (bar_done |=> !bar_done)
    else $error("Barrier done lasted more than one cycle.");

  AST_DONE_AFTER_DRAIN: assert property (s_drain_end |=> bar_done)
    else $error("Barrier drained but no done pulse followed.");

  AST_DONE_NEEDS_TAKE: assert property (s_bar_take |=> !bar_done)
    else $error("Barrier done in the cycle right after it was taken.");

  AST_CTX_REFETCH: assert property (refetch_req |-> bar_done && $past(state_ff.kind) == KIND_CTX)
    else $error("Refetch raised without a completing context barrier.");

  AST_CTX_WAIT: assert property (draining && state_ff.kind == KIND_CTX
                                 && !cnt_zero[CNT_CTX] |=> !bar_done)
    else $error("Context barrier completed with context changes pending.");

  AST_DMB_MAINT: assert property (draining && state_ff.kind == KIND_DMB
                                  && !cnt_zero[CNT_DMNT] |=> !bar_done)
    else $error("Order barrier completed with data maintenance pending.");

  AST_DSB_MAINT: assert property (draining && state_ff.kind == KIND_DSB
                                  && !(cnt_zero[CNT_SMNT] && cnt_zero[CNT_WALK])
                                  |=> !bar_done)
    else $error("Sync barrier completed with maintenance pending.");

  AST_DSB_STALL: assert property (draining && state_ff.kind == KIND_DSB
                                  |-> exec_stall && !send_event_signal && !op_ready)
    else $error("Sync barrier let a later instruction proceed.");

  AST_LD_CLASS: assert property (draining && state_ff.cls == CLS_LD
                                 && state_ff.kind == KIND_DMB
                                 |-> !ld_ready && !st_ready)
    else $error("Load-class barrier let a later access pass.");

  AST_ST_CLASS: assert property (draining && state_ff.cls == CLS_ST
                                 && state_ff.kind == KIND_DMB |-> !st_ready)
    else $error("Store-class barrier let a later store pass.");

  AST_ANY_DONE: assert property (data_bar && state_ff.cls == CLS_ANY
                                 && !(cnt_zero[CNT_LD] && cnt_zero[CNT_ST])
                                 |=> !bar_done)
    else $error("Full barrier completed with accesses outstanding.");

  AST_ACQ_HOLD: assert property (s_acq_issue |=> state_ff.acq_hold
                                 && state_ff.acq_dom == $past(ld_domain))
    else $error("Acquiring load did not arm the ordering hold.");

  AST_ACQ_BLOCK: assert property (state_ff.acq_hold && ld_valid
                                  && ld_domain == state_ff.acq_dom |-> !ld_ready)
    else $error("Load in the acquire domain passed the acquiring load.");

  AST_REL_ORDER: assert property (st_valid && st_ready && st_release
                                  |-> cnt_zero[CNT_LD] && cnt_zero[CNT_ST])
    else $error("Releasing store issued before earlier accesses were observed.");

  AST_SPEC_COUNT: assert property (spec_valid && spec_ready && cnt_zero[CNT_LD]
                                   && !ld_ack |=> !cnt_zero[CNT_LD])
    else $error("Speculative load was not counted as outstanding.");

  // Done can only follow a cycle spent draining.
  AST_NO_DONE_IDLE: assert property (!draining |=> !bar_done)
    else $error("Barrier done without a draining barrier.");

  AST_CTX_END: assert property (s_ctx_end |=> refetch_req && bar_done)
    else $error("Context barrier completed without a refetch request.");

  AST_REFETCH_PULSE: assert property (refetch_req |=> !refetch_req)
    else $error("Refetch request lasted more than one cycle.");

  AST_CTX_STALL: assert property (draining && state_ff.kind == KIND_CTX
                                  |-> exec_stall && !op_ready && !ld_ready && !st_ready)
    else $error("Context barrier let a later instruction proceed.");

  AST_DSB_DMNT: assert property (draining && state_ff.kind == KIND_DSB
                                 && !cnt_zero[CNT_DMNT] |=> !bar_done)
    else $error("Sync barrier completed with data maintenance pending.");

  // Class-qualified waits apply to the two data barriers only, never to a context barrier.
  AST_LD_CLS_WAIT: assert property (data_bar && state_ff.cls == CLS_LD
                                    && !cnt_zero[CNT_LD] |=> !bar_done)
    else $error("Load-class barrier completed with loads outstanding.");

  AST_ST_CLS_WAIT: assert property (data_bar && state_ff.cls == CLS_ST
                                    && !cnt_zero[CNT_ST] |=> !bar_done)
    else $error("Store-class barrier completed with stores outstanding.");

  AST_SPEC_BARRIER: assert property (data_bar && state_ff.cls != CLS_ST
                                     |-> !spec_ready)
    else $error("Speculative load passed a load-ordering barrier.");

  // Acquire and release ordering, exclusive forms included.
  AST_ACQ_ST_BLOCK: assert property (state_ff.acq_hold && st_valid
                                     && st_domain == state_ff.acq_dom |-> !st_ready)
    else $error("Store in the acquire domain passed the acquiring load.");

  AST_ACQ_SYS_BLOCK: assert property (state_ff.acq_hold && ld_valid
                                      && ld_domain == SYSTEM_DOMAIN_ALL |-> !ld_ready)
    else $error("System-wide load passed the acquiring load.");

  AST_ACQ_EXCL: assert property (ld_valid && ld_ready && ld_acquire
                                 && ld_excl |=> state_ff.acq_hold)
    else $error("Acquiring exclusive load did not arm the ordering hold.");

  AST_REL_EXCL: assert property (st_valid && st_ready && st_release && st_excl
                                 |-> cnt_zero[CNT_LD] && cnt_zero[CNT_ST])
    else $error("Releasing exclusive store issued before earlier accesses were observed.");

endmodule : memory_barrier_ordering_unit

// >>> design/barrier_pkg.sv
// Shared constants and types for the memory barrier ordering unit.
package barrier_pkg;

  // Outstanding-operation counters, one per class of tracked traffic.
  localparam int NUM_CNT = 6;
  localparam int CNT_LD = 0;
  localparam int CNT_ST = 1;
  localparam int CNT_DMNT = 2;
  localparam int CNT_SMNT = 3;
  localparam int CNT_CTX = 4;
  localparam int CNT_WALK = 5;
  localparam int CNT_W_DEF = 4;

  // Barrier kinds as presented by the issue stage.
  localparam logic [1:0] KIND_CTX = 2'h1;
  localparam logic [1:0] KIND_DMB = 2'h2;
  localparam logic [1:0] KIND_DSB = 2'h3;

  // Qualifier layout: domain in the upper pair, access class in the lower.
  localparam int QUAL_W = 4;
  localparam int QUAL_DOM_LSB = 2;
  localparam int QUAL_CLS_LSB = 0;

  // Shareability domains.
  localparam logic [1:0] OUTER_DOMAIN_ALL = 2'h0;
  localparam logic [1:0] LOCAL_DOMAIN_ALL = 2'h1;
  localparam logic [1:0] INNER_DOMAIN_ALL = 2'h2;
  localparam logic [1:0] SYSTEM_DOMAIN_ALL = 2'h3;

  // Access classes; code zero is not a legal class.
  localparam logic [1:0] CLS_LD = 2'h1;
  localparam logic [1:0] CLS_ST = 2'h2;
  localparam logic [1:0] CLS_ANY = 2'h3;

  // Barrier sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_DRAIN} bar_state_type;

endpackage : barrier_pkg

// >>> design/outstanding_counter.sv
// Counter of issued but not yet acknowledged operations of one class.
`timescale 1ns/100ps
module outstanding_counter
  import barrier_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic inc,
  input wire logic dec,
  output logic zero,
  output logic full
);

  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cnt_state_type;

  cnt_state_type state_ff;
  cnt_state_type nxt_state;

  // A stray acknowledge on an empty counter is dropped so the count cannot wrap.
  always_comb begin
    nxt_state = state_ff;
    if (inc && !(dec && state_ff.cnt != CNT_ZERO)) begin
      nxt_state.cnt = state_ff.cnt + CNT_ONE;
    end else if (!inc && dec && state_ff.cnt != CNT_ZERO) begin
      nxt_state.cnt = state_ff.cnt - CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Full stalls the source, so no increment arrives while the count is at the maximum.
  assign zero = (state_ff.cnt == CNT_ZERO);
  assign full = (state_ff.cnt == CNT_MAX);

endmodule : outstanding_counter

// >>> design/drain_check.sv
// Decides whether the traffic a pending barrier waits on has fully drained.
`timescale 1ns/100ps
module drain_check
  import barrier_pkg::*;
(
  input wire logic [1:0] kind,
  input wire logic [1:0] cls,
  input wire logic [NUM_CNT-1:0] zero,
  output logic drained
);

  logic acc_ok;

  // Access class picks which earlier data accesses must be acknowledged.
  always_comb begin
    unique case (cls)
      CLS_LD: acc_ok = zero[CNT_LD];
      CLS_ST: acc_ok = zero[CNT_ST];
      default: acc_ok = zero[CNT_LD] & zero[CNT_ST];
    endcase
  end

  // The synchronizing barrier also waits for every maintenance and walker operation.
  always_comb begin
    unique case (kind)
      KIND_CTX: drained = zero[CNT_CTX];
      KIND_DMB: drained = acc_ok & zero[CNT_DMNT];
      KIND_DSB: drained = acc_ok & zero[CNT_DMNT] & zero[CNT_SMNT]
                          & zero[CNT_WALK];
      default: drained = 1'b1;
    endcase
  end

endmodule : drain_check

// >>> tb/mem_system_model.sv
// Behavioural memory system that acknowledges every issued operation class.
`timescale 1ns/100ps
module mem_system_model
  import barrier_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hold,
  input wire logic [NUM_CNT-1:0] issue,
  output logic [NUM_CNT-1:0] ack
);
  typedef struct packed {
    logic [NUM_CNT-1:0][7:0] pend;
    logic [NUM_CNT-1:0] ack;
  } model_state_type;
  model_state_type state_ff;
  model_state_type nxt_state;

  // An ack means the operation is observed; hold stalls the answers so barriers must wait.
  always_comb begin
    nxt_state = state_ff;
    for (int i = 0; i < NUM_CNT; i++) begin
      nxt_state.ack[i] = (state_ff.pend[i] != 8'h00) && !hold;
      nxt_state.pend[i] = state_ff.pend[i] + {7'h00, issue[i]} - {7'h00, nxt_state.ack[i]};
    end
  end

  // Registered answers, never an ack with nothing pending.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ack = state_ff.ack;
endmodule : mem_system_model

// >>> tb/memory_barrier_ordering_unit_tb.sv
// Self-checking bench for the barrier ordering unit against a stalling memory model.
`timescale 1ns/100ps
module memory_barrier_ordering_unit_tb;
  import barrier_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic bar_valid = 1'b0;
  logic [1:0] bar_kind = 2'h0;
  logic [QUAL_W-1:0] bar_qual = 4'h0;
  logic ld_valid = 1'b0;
  logic ld_acquire = 1'b0;
  logic ld_excl = 1'b0;
  logic [1:0] ld_domain = 2'h0;
  logic spec_valid = 1'b0;
  logic st_valid = 1'b0;
  logic st_release = 1'b0;
  logic st_excl = 1'b0;
  logic [1:0] st_domain = 2'h0;
  logic dmnt_valid = 1'b0;
  logic smnt_valid = 1'b0;
  logic ctx_valid = 1'b0;
  logic walk_valid = 1'b0;
  logic send_event_req = 1'b0;
  logic mem_hold = 1'b0;
  logic bar_ready, bar_done, refetch_req, exec_stall, ld_ready, spec_ready, st_ready;
  logic op_ready, send_event_signal, ld_ack, st_ack, dmnt_ack, smnt_ack, ctx_ack, walk_ack;
  logic [1:0] bar_domain;
  logic [NUM_CNT-1:0] issue;
  logic [NUM_CNT-1:0] ack;
  int n_errors = 0;
  int check_count = 0;

  memory_barrier_ordering_unit dut (.clk(clk), .nrst(nrst), .bar_valid(bar_valid),
    .bar_kind(bar_kind), .bar_qual(bar_qual), .bar_ready(bar_ready), .bar_done(bar_done),
    .refetch_req(refetch_req), .bar_domain(bar_domain), .exec_stall(exec_stall),
    .ld_valid(ld_valid), .ld_acquire(ld_acquire), .ld_excl(ld_excl), .ld_domain(ld_domain),
    .ld_ready(ld_ready), .spec_valid(spec_valid), .spec_ready(spec_ready), .ld_ack(ld_ack),
    .st_valid(st_valid), .st_release(st_release), .st_excl(st_excl), .st_domain(st_domain),
    .st_ready(st_ready), .st_ack(st_ack), .dmnt_valid(dmnt_valid), .dmnt_ack(dmnt_ack),
    .smnt_valid(smnt_valid), .smnt_ack(smnt_ack), .ctx_valid(ctx_valid), .ctx_ack(ctx_ack),
    .walk_valid(walk_valid), .walk_ack(walk_ack), .op_ready(op_ready),
    .send_event_req(send_event_req), .send_event_signal(send_event_signal));

  mem_system_model mem (.clk(clk), .nrst(nrst), .hold(mem_hold), .issue(issue), .ack(ack));

  // Issue strobes seen by the memory model, in counter index order.
  assign issue = {walk_valid & op_ready, ctx_valid & op_ready, smnt_valid & op_ready,
    dmnt_valid & op_ready, st_valid & st_ready, (ld_valid & ld_ready) | (spec_valid & spec_ready)};
  assign {walk_ack, ctx_ack, smnt_ack, dmnt_ack, st_ack, ld_ack} = ack;

  // Free-running 50 MHz core clock.
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_up;
    n_errors++;
    $display("mismatch at %0t: wait expired got %h expected %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask : give_up

  // Presents one barrier for a single take edge.
  task automatic take_bar(input logic [1:0] kind, input logic [3:0] qual);
    @(posedge clk);
    bar_valid <= 1'b1;
    bar_kind <= kind;
    bar_qual <= qual;
    #1;
    chk(bar_ready, 1'b1);
    @(posedge clk);
    bar_valid <= 1'b0;
  endtask : take_bar

  // Waits a bounded time for completion; exp_n of zero means any latency is accepted.
  task automatic await_done(input int exp_n, input logic refetch, input logic [1:0] dom);
    int n;
    n = 0;
    while (bar_done !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 100) give_up();
    end
    if (exp_n != 0) chk(n[3:0], exp_n[3:0]);
    chk({refetch_req, bar_ready, bar_domain}, {refetch, 1'b1, dom});
    @(posedge clk);
    #1;
    chk({bar_done, refetch_req}, 2'h0);
  endtask : await_done

  task automatic wait_ready(input logic sel);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 50) give_up();
    end while ((sel ? st_ready : ld_ready) !== 1'b1);
  endtask : wait_ready

  // One operation of class idx for one edge; spec picks the speculative load port.
  task automatic op(input int idx, input logic spec);
    @(posedge clk);
    spec_valid <= spec && idx == CNT_LD;
    ld_valid <= !spec && idx == CNT_LD;
    st_valid <= idx == CNT_ST;
    dmnt_valid <= idx == CNT_DMNT;
    smnt_valid <= idx == CNT_SMNT;
    ctx_valid <= idx == CNT_CTX;
    walk_valid <= idx == CNT_WALK;
    @(posedge clk);
    {spec_valid, ld_valid, st_valid, dmnt_valid, smnt_valid, ctx_valid, walk_valid} <= 7'h00;
  endtask : op

  // Keeps one operation unanswered behind a barrier; gates is {refetch, stall, st, ld ready}.
  task automatic drain(input int idx, input logic spec, input logic [1:0] kind,
    input logic [3:0] qual, input logic [3:0] gates);
    mem_hold <= 1'b1;
    op(idx, spec);
    take_bar(kind, qual);
    send_event_req <= 1'b1;
    repeat (4) begin
      @(posedge clk);
      #1;
      chk({1'b0, exec_stall, st_ready, ld_ready}, {1'b0, gates[2:0]});
      chk({bar_done, op_ready, send_event_signal}, {1'b0, {2{~gates[2]}}});
    end
    @(posedge clk);
    mem_hold <= 1'b0;
    send_event_req <= 1'b0;
    await_done(0, gates[3], qual[3:2]);
    $display("test drain kind %0d class %0d done", kind, idx);
  endtask : drain

  // Unobserved acquiring exclusive load: later accesses in a matching domain are refused.
  task automatic acquire_case;
    mem_hold <= 1'b1;
    @(posedge clk);
    ld_valid <= 1'b1;
    ld_acquire <= 1'b1;
    ld_excl <= 1'b1;
    ld_domain <= 2'h1;
    for (int d = 0; d < 4; d++) begin
      @(posedge clk);
      ld_acquire <= 1'b0;
      ld_excl <= 1'b0;
      ld_domain <= d[1:0];
      st_valid <= 1'b1;
      st_domain <= d[1:0];
      #1;
      chk({ld_ready, st_ready}, {2{d[0] == 1'b0}});
      chk(spec_ready, 1'b0);
    end
    @(posedge clk);
    {ld_valid, st_valid, mem_hold} <= 3'h0;
    ld_domain <= 2'h1;
    wait_ready(1'b0);
    $display("test acquire done");
  endtask : acquire_case

  // A releasing exclusive store stays refused while an earlier load is unobserved.
  task automatic release_case;
    mem_hold <= 1'b1;
    op(CNT_LD, 1'b0);
    @(posedge clk);
    {st_valid, st_release, st_excl} <= 3'h7;
    st_domain <= 2'h2;
    repeat (3) begin
      #1;
      chk(st_ready, 1'b0);
      @(posedge clk);
    end
    mem_hold <= 1'b0;
    wait_ready(1'b1);
    @(posedge clk);
    {st_valid, st_release, st_excl} <= 3'h0;
    $display("test release done");
  endtask : release_case

  // Main sequence: reset, qualifier table, drains, one-way barriers.
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk({bar_ready, bar_done, refetch_req, exec_stall}, 4'h8);
    chk({ld_ready, st_ready, op_ready, spec_ready}, 4'hf);
    chk(bar_domain, 2'h3);
    $display("test reset done");
    // Kind and class code zero are included; with nothing outstanding done follows one edge on.
    for (int k = 0; k < 4; k++) begin
      for (int d = 0; d < 4; d++) begin
        for (int c = 0; c < 4; c++) begin
          take_bar(k[1:0], {d[1:0], c[1:0]});
          await_done(1, k == 1, d[1:0]);
        end
      end
    end
    $display("test qualifier table done");
    drain(CNT_LD, 1'b0, KIND_DMB, {INNER_DOMAIN_ALL, CLS_LD}, 4'h0);
    drain(CNT_ST, 1'b0, KIND_DMB, {OUTER_DOMAIN_ALL, CLS_ST}, 4'h1);
    drain(CNT_DMNT, 1'b0, KIND_DMB, {LOCAL_DOMAIN_ALL, CLS_ANY}, 4'h0);
    drain(CNT_SMNT, 1'b0, KIND_DSB, {SYSTEM_DOMAIN_ALL, CLS_ANY}, 4'h4);
    drain(CNT_WALK, 1'b0, KIND_DSB, {INNER_DOMAIN_ALL, CLS_LD}, 4'h4);
    drain(CNT_CTX, 1'b0, KIND_CTX, {SYSTEM_DOMAIN_ALL, CLS_ANY}, 4'hc);
    drain(CNT_LD, 1'b1, KIND_DMB, {SYSTEM_DOMAIN_ALL, CLS_LD}, 4'h0);
    acquire_case();
    release_case();
    tally_and_finish();
  end
endmodule : memory_barrier_ordering_unit_tb
